// [shared/scm_cfg.svh]
// Constants of the synthesizer configuration mailbox
`ifndef SCM_CFG_SVH
`define SCM_CFG_SVH

// Synthesizer count, index width and stored configuration width
`define SCM_NUM_SYNTH  5
`define SCM_IDX_W      3
`define SCM_CFG_W      80

// Term positions inside one stored configuration word
`define SCM_BASE_POS   64
`define SCM_MULT_POS   32
`define SCM_NUM_POS    16
`define SCM_DEN_POS    0
`define SCM_TERM16_W   16
`define SCM_TERM32_W   32

// Byte lanes of the multi-byte words, most significant first
`define SCM_B3         31:24
`define SCM_B2         23:16
`define SCM_B1         15:8
`define SCM_B0         7:0

// Page byte addresses
`define SCM_ADDR_SEL_HI  16'h0682
`define SCM_ADDR_SEL_LO  16'h0683
`define SCM_ADDR_SEM     16'h0684
`define SCM_ADDR_BASE_HI 16'h0686
`define SCM_ADDR_BASE_LO 16'h0687
`define SCM_ADDR_MULT_B3 16'h0688
`define SCM_ADDR_MULT_B2 16'h0689
`define SCM_ADDR_MULT_B1 16'h068a
`define SCM_ADDR_MULT_B0 16'h068b
`define SCM_ADDR_NUM_HI  16'h068c
`define SCM_ADDR_NUM_LO  16'h068d
`define SCM_ADDR_DEN_HI  16'h068e
`define SCM_ADDR_DEN_LO  16'h068f

// Handshake bits
`define SCM_SEM_FETCH  1
`define SCM_SEM_APPLY  0
`define SCM_SEM_IDLE   2'h0

// Reset values
`define SCM_SEL_RST    16'h0001
`define SCM_BASE_RST   16'h0001
`define SCM_MULT_RST   32'h12a05f20
`define SCM_NUM_RST    16'h0001
`define SCM_DEN_RST    16'h0001
`define SCM_CFG_RST    {`SCM_BASE_RST, `SCM_MULT_RST, `SCM_NUM_RST, `SCM_DEN_RST}
`define SCM_BYTE_ZERO  8'h00

`endif

// [shared/scm_pkg.sv]
// Types of the synthesizer configuration mailbox
package scm_pkg;

	// Transfer state, one-hot
	typedef enum logic [2:0] {
		st_idle  = 3'h1,
		st_apply = 3'h2,
		st_fetch = 3'h4
	} scm_state_t;

endpackage : scm_pkg

// [src/scm_cfg_store.sv]
// Per-synthesizer configuration stores with masked write
`timescale 1ns/1ns
`default_nettype none
`include "scm_cfg.svh"

module scm_cfg_store
	import scm_pkg::*;
#(
	parameter int NUM = `SCM_NUM_SYNTH,
	parameter int W   = `SCM_CFG_W
)
(
	// Clock and reset
	input  wire logic                  clk,
	input  wire logic                  rst_n,
	// Masked write
	input  wire logic                  wr_en,
	input  wire logic [NUM-1:0]        wr_mask,
	input  wire logic [W-1:0]          wr_data,
	// Indexed read
	input  wire logic [`SCM_IDX_W-1:0] rd_idx,
	output logic      [W-1:0]          rd_data,
	// All stores, flat, to the synthesizers
	output logic      [NUM*W-1:0]      cfg_flat
);

	// Reset value is packed at the fixed word width only
	if (W != `SCM_CFG_W || NUM < 1 || NUM > (1 << `SCM_IDX_W))
		$error("scm_cfg_store: unsupported width or count");

	logic [W-1:0] mem_r   [NUM];  // Stored configurations
	logic [W-1:0] mem_nxt [NUM];  // Next stored configurations

	// Each store takes the staged word only when its mask bit is set
	always_comb
	begin
		for (int i = 0; i < NUM; i++)
		begin
			mem_nxt[i] = (wr_en && wr_mask[i]) ? wr_data : mem_r[i];
		end
	end

	// Stores power up with the page defaults
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			for (int i = 0; i < NUM; i++)
			begin
				mem_r[i] <= `SCM_CFG_RST;
			end
		end
		else
		begin
			mem_r <= mem_nxt;
		end
	end

	// Index is kept below NUM by the caller
	assign rd_data = mem_r[rd_idx];

	// Flatten for the synthesizer side
	for (genvar g = 0; g < NUM; g++)
	begin : g_flat
		assign cfg_flat[g*W +: W] = mem_r[g];
	end

endmodule : scm_cfg_store

`default_nettype wire

// [src/scm_mailbox.sv]
// Synthesizer configuration mailbox: page registers and transfer control
`timescale 1ns/1ns
`default_nettype none
`include "scm_cfg.svh"

// Summary of operation
// - Apply writes all selected synthesizers together
// - Selection bit n addresses synthesizer n
// - Fetch bit copies store into page
// - Handshake reads zero once fetch finished
// - Apply bit, fetch clear, writes page out
// - Handshake reads zero once apply finished
// - Frequency is base times multiplier, numerator, denominator
// - Multiplier is a 32-bit staged page word
// - Numerator and denominator are 16-bit page words
module scm_mailbox
	import scm_pkg::*;
#(
	parameter int NUM_SYNTH = `SCM_NUM_SYNTH
)
(
	// Clock and reset
	input  wire logic                             clk,
	input  wire logic                             rst_n,
	// Byte register port from the processor interface
	input  wire logic [15:0]                      bus_addr,
	input  wire logic [7:0]                       bus_wdata,
	input  wire logic                             bus_wr,
	input  wire logic                             bus_rd,
	output logic      [7:0]                       bus_rdata,
	output logic                                  bus_rvalid,
	// Stored terms for every synthesizer
	output logic      [NUM_SYNTH*`SCM_CFG_W-1:0]  synth_cfg
);

	// Selection field is five bits wide at most
	if (NUM_SYNTH < 1 || NUM_SYNTH > `SCM_NUM_SYNTH)
		$error("scm_mailbox: NUM_SYNTH out of range");

	localparam int W = `SCM_CFG_W;

	scm_state_t                  state_r, state_nxt;  // Transfer state
	logic [NUM_SYNTH-1:0]        sel_r, sel_nxt;      // Target selection
	logic [1:0]                  sem_r, sem_nxt;      // Handshake bits
	logic [15:0]                 base_r, base_nxt;    // base_term
	logic [31:0]                 mult_r, mult_nxt;    // multiplier_term
	logic [15:0]                 num_r, num_nxt;      // numerator_term
	logic [15:0]                 den_r, den_nxt;      // denominator_term
	logic [7:0]                  rd_byte;             // Read mux result
	logic [7:0]                  rdata_r;             // Registered read data
	logic                        rvalid_r;            // Read answer pulse
	logic [W-1:0]                page_cfg;            // Staged configuration
	logic [W-1:0]                store_rd;            // Store read word
	logic [`SCM_IDX_W-1:0]       fetch_idx;           // Store being fetched
	logic [15:0]                 sel_word;            // Selection, widened

	// Lowest selected synthesizer; a clean fetch has only one bit set
	function automatic logic [`SCM_IDX_W-1:0] first_sel(
		input logic [NUM_SYNTH-1:0] m
	);
		logic [`SCM_IDX_W-1:0] idx;
		idx = '0;
		for (int i = NUM_SYNTH - 1; i >= 0; i--)
		begin
			if (m[i])
			begin
				idx = `SCM_IDX_W'(i);
			end
		end
		return idx;
	endfunction : first_sel

	// Staged word in store layout; the synthesizer forms its output
	// frequency from these four terms
	assign page_cfg  = {base_r, mult_r, num_r, den_r};
	assign fetch_idx = first_sel(sel_r);
	assign sel_word  = 16'(sel_r);

	// Masked configuration stores
	scm_cfg_store #(
		.NUM      (NUM_SYNTH),
		.W        (W)
	) u_store (
		.clk      (clk),
		.rst_n    (rst_n),
		.wr_en    (state_r == st_apply),
		.wr_mask  (sel_r),
		.wr_data  (page_cfg),
		.rd_idx   (fetch_idx),
		.rd_data  (store_rd),
		.cfg_flat (synth_cfg)
	);

	// Register writes and transfer sequencing
	always_comb
	begin
		state_nxt = state_r;
		sel_nxt   = sel_r;
		sem_nxt   = sem_r;
		base_nxt  = base_r;
		mult_nxt  = mult_r;
		num_nxt   = num_r;
		den_nxt   = den_r;
		unique case (state_r)
			st_idle:
			begin
				// Writes are taken only when idle, so a transfer sees
				// a stable page even if the host misbehaves
				if (bus_wr)
				begin
					case (bus_addr)
						`SCM_ADDR_SEL_LO:  sel_nxt = bus_wdata[NUM_SYNTH-1:0];
						`SCM_ADDR_BASE_HI: base_nxt[`SCM_B1] = bus_wdata;
						`SCM_ADDR_BASE_LO: base_nxt[`SCM_B0] = bus_wdata;
						`SCM_ADDR_MULT_B3: mult_nxt[`SCM_B3] = bus_wdata;
						`SCM_ADDR_MULT_B2: mult_nxt[`SCM_B2] = bus_wdata;
						`SCM_ADDR_MULT_B1: mult_nxt[`SCM_B1] = bus_wdata;
						`SCM_ADDR_MULT_B0: mult_nxt[`SCM_B0] = bus_wdata;
						`SCM_ADDR_NUM_HI:  num_nxt[`SCM_B1] = bus_wdata;
						`SCM_ADDR_NUM_LO:  num_nxt[`SCM_B0] = bus_wdata;
						`SCM_ADDR_DEN_HI:  den_nxt[`SCM_B1] = bus_wdata;
						`SCM_ADDR_DEN_LO:  den_nxt[`SCM_B0] = bus_wdata;
						`SCM_ADDR_SEM:
						begin
							// Fetch outranks apply when both are written
							if (bus_wdata[`SCM_SEM_FETCH])
							begin
								sem_nxt   = bus_wdata[1:0];
								state_nxt = st_fetch;
							end
							else if (bus_wdata[`SCM_SEM_APPLY])
							begin
								sem_nxt   = bus_wdata[1:0];
								state_nxt = st_apply;
							end
						end
						default:
						begin
							// Unmapped or read-only: ignored
						end
					endcase
				end
			end
			st_apply:
			begin
				// Stores take the page this cycle; release handshake
				sem_nxt   = `SCM_SEM_IDLE;
				state_nxt = st_idle;
			end
			st_fetch:
			begin
				// Load the selected store back into the page
				base_nxt  = store_rd[`SCM_BASE_POS +: `SCM_TERM16_W];
				mult_nxt  = store_rd[`SCM_MULT_POS +: `SCM_TERM32_W];
				num_nxt   = store_rd[`SCM_NUM_POS +: `SCM_TERM16_W];
				den_nxt   = store_rd[`SCM_DEN_POS +: `SCM_TERM16_W];
				sem_nxt   = `SCM_SEM_IDLE;
				state_nxt = st_idle;
			end
			default:
			begin
				// Illegal code recovers to idle
				sem_nxt   = `SCM_SEM_IDLE;
				state_nxt = st_idle;
			end
		endcase
	end

	// Page and control registers
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_r <= st_idle;
			sel_r   <= NUM_SYNTH'(`SCM_SEL_RST);
			sem_r   <= `SCM_SEM_IDLE;
			base_r  <= `SCM_BASE_RST;
			mult_r  <= `SCM_MULT_RST;
			num_r   <= `SCM_NUM_RST;
			den_r   <= `SCM_DEN_RST;
		end
		else
		begin
			state_r <= state_nxt;
			sel_r   <= sel_nxt;
			sem_r   <= sem_nxt;
			base_r  <= base_nxt;
			mult_r  <= mult_nxt;
			num_r   <= num_nxt;
			den_r   <= den_nxt;
		end
	end

	// Read mux; reserved bits and unmapped bytes read zero
	always_comb
	begin
		rd_byte = `SCM_BYTE_ZERO;
		case (bus_addr)
			`SCM_ADDR_SEL_HI:  rd_byte = sel_word[`SCM_B1];
			`SCM_ADDR_SEL_LO:  rd_byte = sel_word[`SCM_B0];
			`SCM_ADDR_SEM:     rd_byte = 8'(sem_r);
			`SCM_ADDR_BASE_HI: rd_byte = base_r[`SCM_B1];
			`SCM_ADDR_BASE_LO: rd_byte = base_r[`SCM_B0];
			`SCM_ADDR_MULT_B3: rd_byte = mult_r[`SCM_B3];
			`SCM_ADDR_MULT_B2: rd_byte = mult_r[`SCM_B2];
			`SCM_ADDR_MULT_B1: rd_byte = mult_r[`SCM_B1];
			`SCM_ADDR_MULT_B0: rd_byte = mult_r[`SCM_B0];
			`SCM_ADDR_NUM_HI:  rd_byte = num_r[`SCM_B1];
			`SCM_ADDR_NUM_LO:  rd_byte = num_r[`SCM_B0];
			`SCM_ADDR_DEN_HI:  rd_byte = den_r[`SCM_B1];
			`SCM_ADDR_DEN_LO:  rd_byte = den_r[`SCM_B0];
			default:           rd_byte = `SCM_BYTE_ZERO;
		endcase
	end

	// Read answer registered one cycle after the strobe
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rdata_r  <= `SCM_BYTE_ZERO;
			rvalid_r <= 1'b0;
		end
		else
		begin
			rdata_r  <= bus_rd ? rd_byte : rdata_r;
			rvalid_r <= bus_rd;
		end
	end

	assign bus_rdata  = rdata_r;
	assign bus_rvalid = rvalid_r;

	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	sequence s_sem_wr;
		state_r == st_idle && bus_wr && bus_addr == `SCM_ADDR_SEM;
	endsequence
	sequence s_apply_req;
		s_sem_wr and (!bus_wdata[`SCM_SEM_FETCH] && bus_wdata[`SCM_SEM_APPLY]);
	endsequence
	sequence s_fetch_req;
		s_sem_wr and bus_wdata[`SCM_SEM_FETCH];
	endsequence

	a_apply_done: assert property (s_apply_req |=> state_r == st_apply &&
		sem_r != `SCM_SEM_IDLE ##1 sem_r == `SCM_SEM_IDLE && state_r == st_idle)
		else $error("apply did not finish in two cycles");
	a_fetch_done: assert property (s_fetch_req |=> state_r == st_fetch &&
		sem_r != `SCM_SEM_IDLE ##1 sem_r == `SCM_SEM_IDLE && state_r == st_idle)
		else $error("fetch did not finish in two cycles");
	a_fetch_prio: assert property (s_fetch_req |=> state_r != st_apply)
		else $error("apply started while fetch bit set");
	a_fetch_load: assert property (state_r == st_fetch |=>
		page_cfg == $past(store_rd))
		else $error("fetch did not load the page");
	a_sem_busy: assert property (sem_r != `SCM_SEM_IDLE |->
		state_r != st_idle)
		else $error("handshake busy with no transfer");
	a_read_sem: assert property (bus_rd && bus_addr == `SCM_ADDR_SEM |=>
		bus_rvalid && bus_rdata == {6'h00, $past(sem_r)})
		else $error("handshake read back wrong");
	a_mult_write: assert property (state_r == st_idle && bus_wr &&
		bus_addr == `SCM_ADDR_MULT_B0 |=> mult_r[`SCM_B0] == $past(bus_wdata))
		else $error("multiplier byte not stored");
	a_den_write: assert property (state_r == st_idle && bus_wr &&
		bus_addr == `SCM_ADDR_DEN_HI |=> den_r[`SCM_B1] == $past(bus_wdata))
		else $error("denominator byte not stored");

	// Per-store checks; the fetch index is judged from the selection bit
	for (genvar g = 0; g < NUM_SYNTH; g++)
	begin : g_chk
		a_fetch_index: assert property (state_r == st_fetch &&
			sel_r == NUM_SYNTH'(1 << g) |-> store_rd == synth_cfg[g*W +: W])
			else $error("fetch read the wrong store");
		a_apply_store: assert property (state_r == st_apply && sel_r[g] |=>
			synth_cfg[g*W +: W] == $past(page_cfg))
			else $error("selected store not written");
		a_apply_keep: assert property (state_r == st_apply && !sel_r[g] |=>
			$stable(synth_cfg[g*W +: W]))
			else $error("unselected store changed");
		a_base_field: assert property (state_r == st_apply && sel_r[g] |=>
			synth_cfg[g*W + `SCM_BASE_POS +: `SCM_TERM16_W] == $past(base_r))
			else $error("base term misplaced in store");
	end

endmodule : scm_mailbox

`default_nettype wire

// [bench/test_synth_config_mailbox.sv]
// Self-checking bench for the synthesizer configuration mailbox
`timescale 1ns/1ns
`default_nettype none
`include "scm_cfg.svh"

module test_synth_config_mailbox
	import scm_pkg::*;
;
	// Clock and reset
	logic                          clk;
	logic                          rst_n;
	// Byte register port
	logic [15:0]                   bus_addr;
	logic [7:0]                    bus_wdata;
	logic                          bus_wr;
	logic                          bus_rd;
	logic [7:0]                    bus_rdata;
	logic                          bus_rvalid;
	// Stores seen by the synthesizers
	logic [5*`SCM_CFG_W-1:0]       synth_cfg;
	// Expected store contents
	logic [`SCM_CFG_W-1:0]         model [5];
	// Tallies
	int                            err_total;
	int                            tests_run;

	// Terms are base, multiplier, numerator, denominator
	localparam logic [79:0] CFG_DEF = 80'h0001_12a05f20_0001_0001;
	// Base 1, 375 MHz: kept inside the legal window
	localparam logic [79:0] CFG_A = 80'h0001_0ee6b280_0003_0002;
	// Base 2 divides 500 MHz evenly, 250 MHz
	localparam logic [79:0] CFG_B = 80'h0002_05f5e100_0005_0004;

	scm_mailbox dut_u (
		.clk        (clk),
		.rst_n      (rst_n),
		.bus_addr   (bus_addr),
		.bus_wdata  (bus_wdata),
		.bus_wr     (bus_wr),
		.bus_rd     (bus_rd),
		.bus_rdata  (bus_rdata),
		.bus_rvalid (bus_rvalid),
		.synth_cfg  (synth_cfg)
	);

	// Free-running 125 MHz clock
	initial
	begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	// Compare and tally
	task automatic check(input string name, input logic [79:0] seen,
		input logic [79:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			err_total++;
			$display("BAD %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	// Verdict and end of run
	task automatic finish_test();
		if (err_total == 0 && tests_run > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : finish_test

	// One byte write; a gap cycle keeps strobes from being reassigned
	task automatic wr_byte(input logic [15:0] a, input logic [7:0] d);
		@(negedge clk);
		bus_addr  = a;
		bus_wdata = d;
		bus_wr    = 1'b1;
		@(negedge clk);
		bus_wr    = 1'b0;
	endtask : wr_byte

	// One byte read; answer stands for exactly one cycle
	task automatic rd_byte(input logic [15:0] a, output logic [7:0] d);
		@(negedge clk);
		bus_addr = a;
		bus_rd   = 1'b1;
		@(negedge clk);
		bus_rd   = 1'b0;
		check("read valid", {79'h0, bus_rvalid}, 80'h1);
		d = bus_rdata;
	endtask : rd_byte

	// Stage selection and all page terms, most significant byte first
	task automatic put_cfg(input logic [79:0] c, input logic [7:0] sel);
		wr_byte(`SCM_ADDR_SEL_LO, sel);
		for (int i = 0; i < 10; i++)
			wr_byte(`SCM_ADDR_BASE_HI + 16'(i), c[79-8*i -: 8]);
	endtask : put_cfg

	// Read the whole page of terms back
	task automatic get_page(output logic [79:0] c);
		logic [7:0] b;
		for (int i = 0; i < 10; i++)
		begin
			rd_byte(`SCM_ADDR_BASE_HI + 16'(i), b);
			c[79-8*i -: 8] = b;
		end
	endtask : get_page

	// Start a transfer, poll until the handshake clears
	task automatic kick(input logic [7:0] v);
		logic [7:0] b;
		wr_byte(`SCM_ADDR_SEM, v);
		// Page is left alone until idle
		for (int n = 0; n < 8; n++)
		begin
			rd_byte(`SCM_ADDR_SEM, b);
			if (b === 8'h00)
				break;
		end
		check("handshake idle", {72'h0, b}, 80'h0);
	endtask : kick

	// Every store against the model
	task automatic check_stores();
		for (int k = 0; k < 5; k++)
			check("store", synth_cfg[k*80 +: 80], model[k]);
	endtask : check_stores

	// Reset defaults of stores, page and selection
	task automatic t_reset();
		logic [79:0] p;
		logic [7:0]  b;
		for (int k = 0; k < 5; k++)
			model[k] = CFG_DEF;
		check_stores();
		get_page(p);
		check("page reset", p, CFG_DEF);
		rd_byte(`SCM_ADDR_SEL_HI, b);
		check("select hi", {72'h0, b}, 80'h0);
		rd_byte(`SCM_ADDR_SEL_LO, b);
		check("select lo", {72'h0, b}, 80'h1);
		rd_byte(16'h0685, b);
		// Unmapped byte reads zero
		check("unmapped", {72'h0, b}, 80'h0);
	endtask : t_reset

	// Apply to a selection, only selected stores change
	task automatic t_apply(input logic [79:0] c, input logic [7:0] sel);
		logic [7:0] b;
		put_cfg(c, sel);
		rd_byte(`SCM_ADDR_SEL_LO, b);
		check("select back", {72'h0, b}, {72'h0, sel});
		kick(8'h01);
		for (int k = 0; k < 5; k++)
			if (sel[k])
				model[k] = c;
		check_stores();
	endtask : t_apply

	// Fetch each synthesizer; apply bit set too must be ignored
	task automatic t_fetch();
		logic [79:0] p;
		for (int i = 0; i < 5; i++)
		begin
			// Single bit: a fetch returns one synthesizer
			put_cfg(CFG_A, 8'(1 << i));
			// Handshake write of zero must start nothing
			wr_byte(`SCM_ADDR_SEM, 8'h00);
			kick(8'h03);
			get_page(p);
			check("fetched page", p, model[i]);
			check_stores();
		end
	endtask : t_fetch

	// Hang guard, far above the few hundred cycles needed
	initial
	begin
		repeat (40000) @(posedge clk);
		err_total++;
		finish_test();
	end

	// Main sequence
	initial
	begin
		rst_n     = 1'b0;
		bus_addr  = 16'h0000;
		bus_wdata = 8'h00;
		bus_wr    = 1'b0;
		bus_rd    = 1'b0;
		err_total = 0;
		tests_run = 0;
		repeat (10) @(posedge clk);
		@(negedge clk);
		rst_n = 1'b1;
		t_reset();
		// Several stores in one operation
		t_apply(CFG_A, 8'h15);
		// Each selection bit on its own; numerator 5 to 9 keeps the
		// frequency between 250 and 450 MHz, inside the legal window
		for (int i = 0; i < 5; i++)
			t_apply(CFG_B + (80'(i) << `SCM_NUM_POS), 8'(1 << i));
		t_fetch();
		// Second reset in mid-run restores every default
		@(negedge clk);
		rst_n = 1'b0;
		repeat (2) @(negedge clk);
		rst_n = 1'b1;
		t_reset();
		finish_test();
	end

endmodule : test_synth_config_mailbox
`default_nettype wire
